//--- tb.sv
`timescale 1ns/1ps
module tb;
  import vsw_pkg::*;
  localparam int WDOG = 40000;
  logic        sys_clk;
  logic        rst_n;
  logic        addr_sel;
  logic [3:0]  cable;
  logic        scl;
  logic        pull;
  logic        sda_oe;
  logic        sda_o_w;
  wire         sda_w = !(pull || sda_oe);
  logic [7:0]  rd_byte;
  logic        rd_valid;
  logic        ack_bit;
  logic        ack_valid;
  logic        glitch;
  logic        global_en;
  logic        field_inv;
  logic [1:0]  cvbs, luma, chroma, yclamp, prpb, lofs;
  wire  [13:0] outs = {global_en, field_inv, cvbs, luma, chroma, yclamp,
                       prpb, lofs};
  logic        exp_ack[$];
  logic [7:0]  exp_rd[$];
  int          failures = 0;
  int          n_checks = 0;
  logic [31:0] rnd = 32'h000101f9;

  vsw_i2c_cfg dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o_w), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel),
    .cable_absent_i(cable), .global_en_o(global_en),
    .field_inv_o(field_inv), .cvbs_clamp_dis_o(cvbs),
    .svid_luma_clamp_dis_o(luma), .svid_chroma_clamp_dis_o(chroma),
    .comp_y_clamp_dis_o(yclamp), .comp_prpb_clamp_dis_o(prpb),
    .comp_low_offset_o(lofs));

  // Shortest phases that still clear the filter and the answer delay
  vsw_host_bfm #(.LO(8), .HI(4)) host (
    .sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull),
    .rd_byte_o(rd_byte), .rd_valid_o(rd_valid), .ack_o(ack_bit),
    .ack_valid_o(ack_valid), .glitch_o(glitch));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < 32; i++) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction : lfsr

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic note(input logic ok, input string what,
                      input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (!ok) begin
      failures++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : note

  task automatic chk_ack(input logic got);
    logic e;
    e = (exp_ack.size() > 0) ? exp_ack.pop_front() : 1'bx;
    note(got === e, "ack bit", {15'h0, got}, {15'h0, e});
  endtask : chk_ack

  task automatic chk_rd(input logic [7:0] got);
    logic [7:0] e;
    e = (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hxx;
    note(got === e, "read byte", {8'h0, got}, {8'h0, e});
  endtask : chk_rd

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    note(got === exp, what, got, exp);
  endtask : chk_val

  task automatic wb(input logic [7:0] b, input logic a);
    exp_ack.push_back(a);
    host.wr_byte(b);
  endtask : wb

  task automatic rb(input logic [7:0] d, input logic last);
    exp_rd.push_back(d);
    host.rd_byte(last);
  endtask : rb

  always @(posedge sys_clk) begin
    if (ack_valid === 1'b1) chk_ack(ack_bit);
    if (rd_valid === 1'b1) chk_rd(rd_byte);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_pass(input logic sel);
    logic [7:0] aw, m1, rs, m2;
    logic [7:0] cfg [8];
    aw = {DEV_ADDR_HI, sel, 1'b0};
    rnd = lfsr(rnd);
    m1 = rnd[7:0];
    rs = rnd[15:8];
    m2 = rnd[23:16] | 8'h24;
    cfg = '{sel ? 8'h23 : 8'h25, sel ? 8'hab : 8'h24, 8'h00, 8'h00,
            8'h80, 8'h80, 8'hfc, 8'hfc};
    addr_sel <= sel;
    cable <= rnd[27:24];
    repeat (8) @(posedge sys_clk);
    host.start();
    wb(aw, 1'b0);
    wb(REG_SEP_A, 1'b0);
    foreach (cfg[i]) wb(cfg[i], 1'b0);
    host.start();
    wb(aw, 1'b0);
    wb(REG_MISC1, 1'b0);
    wb(m1, 1'b0);
    wb(rs, 1'b0);
    wb(m2, 1'b0);
    host.stop();
    host.start();
    wb(aw ^ 8'h02, 1'b1);
    wb(REG_MISC2, 1'b1);
    wb(8'h00, 1'b1);
    host.stop();
    host.start();
    wb(aw, 1'b0);
    wb(REG_MISC1, 1'b0);
    host.start();
    wb(aw | 8'h01, 1'b0);
    rb({rnd[27:24], m1[3:0]}, 1'b0);
    rb(8'h00, 1'b0);
    rb(m2, 1'b1);
    host.stop();
    host.start();
    wb(aw | 8'h01, 1'b0);
    rb(8'h00, 1'b1);
    host.stop();
    repeat (4) @(posedge sys_clk);
    chk_val({2'b0, outs}, {2'b0, m1[0], m1[1], m2[4], m2[0], m2[5], m2[1],
            m2[5] & !sel, 1'b0, m2[6], m2[2], 1'b0, m2[2] & !sel,
            m2[7], m2[3]}, "clamp controls");
  endtask : run_pass

  initial begin
    rst_n <= 1'b0;
    addr_sel <= 1'b0;
    cable <= 4'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk_val({2'b0, outs}, 16'h0000, "outputs after reset");
    run_pass(1'b0);
    run_pass(1'b1);
    chk_val({15'h0, glitch}, 16'h0000, "data moved in clock high");
    chk_val({15'h0, sda_o_w}, 16'h0000, "data pin drive level");
    chk_val({8'h0, 7'h0, exp_ack.size() + exp_rd.size() == 0}, 16'h0001,
            "results missing");
    conclude();
  end

  initial begin
    repeat (WDOG) @(posedge sys_clk);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb

//--- vsw_host_bfm.sv
`timescale 1ns/1ps
module vsw_host_bfm #(
  parameter int LO = 10,
  parameter int HI = 6
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_pull_o,
  output logic [7:0]      rd_byte_o,
  output logic            rd_valid_o,
  output logic            ack_o,
  output logic            ack_valid_o,
  output logic            glitch_o
);
  logic own;
  logic sda_q;
  logic scl_q;

  initial begin
    scl_o       = 1'b1;
    sda_pull_o  = 1'b0;
    rd_byte_o   = 8'h00;
    rd_valid_o  = 1'b0;
    ack_o       = 1'b0;
    ack_valid_o = 1'b0;
    glitch_o    = 1'b0;
    own         = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags a data line move in clock high that the host did not make
  always @(posedge sys_clk_i) begin
    if (scl_o && scl_q && !own && sda_i !== sda_q)
      glitch_o <= 1'b1;
    sda_q <= sda_i;
    scl_q <= scl_o;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wait_clk

  // Data moves only in the low phase; the line is read at the end of high
  task automatic bit_xfer(input logic b, output logic s);
    scl_o <= 1'b0;
    wait_clk(LO / 2);
    sda_pull_o <= ~b;
    wait_clk(LO - LO / 2);
    scl_o <= 1'b1;
    wait_clk(HI);
    s = sda_i;
  endtask : bit_xfer

  // Data line set in low phase, then moved while the clock is high
  task automatic cond(input logic mid, input logic fin);
    scl_o <= 1'b0;
    wait_clk(LO / 2);
    sda_pull_o <= mid;
    wait_clk(LO - LO / 2);
    scl_o <= 1'b1;
    wait_clk(HI / 2);
    own = 1'b1;
    sda_pull_o <= fin;
    wait_clk(HI - HI / 2);
    own = 1'b0;
  endtask : cond

  task automatic start();
    cond(1'b0, 1'b1);
  endtask : start

  task automatic stop();
    cond(1'b1, 1'b0);
  endtask : stop

  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack_o       <= s;
    ack_valid_o <= 1'b1;
    wait_clk(1);
    ack_valid_o <= 1'b0;
  endtask : wr_byte

  task automatic rd_byte(input logic last);
    logic [7:0] d;
    logic       s;
    d = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(last, s);
    rd_byte_o  <= d;
    rd_valid_o <= 1'b1;
    wait_clk(1);
    rd_valid_o <= 1'b0;
  endtask : rd_byte
endmodule : vsw_host_bfm

//--- vsw_i2c_cfg.sv
`timescale 1ns/1ps
// Overview of operation
// - Seven-bit bus address: fixed upper six bits, low bit from select pin.
// - Address select reads as zero when open; pad pull-down holds it low.
// - Eighth address bit picks direction: one read, zero write.
// - Host opens with START; device ignores everything until a START.
// - Matching address byte is acknowledged in the next acknowledge clock.
// - STOP or repeated START ends a transfer; repeated START turns direction.
// - Serial clock filtered three crystal periods; data taken on its rise.
// - Read data changes only after the filtered serial clock falls.
// - Write: address byte, register index, then data bytes from there.
// - Pointer advances after each written data byte.
// - Reads return register at pointer, then pointer advances.
// - First misc register bits 4..7 show S-Video cable absent, inputs 0..3.
// - Second misc bits 0 and 4 disable composite B and A clamps.
// - Bits 1/5 kill S-Video luma clamp; chroma only in slave with 0x25.
// - Bits 2/6 kill component Y clamp; Pr/Pb only in slave with 0x24.
// - Bits 3/7 select low-offset clamp mode for component B and A.
// - First misc register bits 4..7 ignore host writes.
module vsw_i2c_cfg (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o,
  input  wire logic                        addr_sel_i,
  input  wire logic [vsw_pkg::CABLE_W-1:0] cable_absent_i,
  output logic                             global_en_o,
  output logic                             field_inv_o,
  output logic [1:0]                       cvbs_clamp_dis_o,
  output logic [1:0]                       svid_luma_clamp_dis_o,
  output logic [1:0]                       svid_chroma_clamp_dis_o,
  output logic [1:0]                       comp_y_clamp_dis_o,
  output logic [1:0]                       comp_prpb_clamp_dis_o,
  output logic [1:0]                       comp_low_offset_o
);
  import vsw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial line filters
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [1:0] flt;
  logic [1:0] prev_reg;
  logic       scl_f;
  logic       sda_f;
  logic       addr_sel_s;
  logic [3:0] cable_s;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {addr_sel_i, cable_absent_i, sda_i, scl_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign addr_sel_s = sync2_reg[6];
  assign cable_s    = sync2_reg[5:2];

  for (genvar g = 0; g < 2; g++) begin : g_flt
    logic [1:0] cnt_reg;
    logic       f_reg;
    // A line level is taken only after three steady crystal samples
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_reg <= 2'h0;
        f_reg   <= 1'b1;
      end else if (sync2_reg[g] == f_reg) begin
        cnt_reg <= 2'h0;
      end else if (cnt_reg == GLITCH_MAX) begin
        f_reg   <= sync2_reg[g];
        cnt_reg <= 2'h0;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
    assign flt[g] = f_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) prev_reg <= 2'h3;
    else          prev_reg <= flt;
  end

  assign scl_f = flt[0];
  assign sda_f = flt[1];

  wire scl_rise  = scl_f & ~prev_reg[0];
  wire scl_fall  = ~scl_f & prev_reg[0];
  wire start_det = scl_f & prev_reg[0] & ~sda_f & prev_reg[1];
  wire stop_det  = scl_f & prev_reg[0] & sda_f & ~prev_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer
  vsw_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       rw_reg, rw_next;
  logic       ack_reg, ack_next;
  logic       sdoe_reg, sdoe_next;
  logic [7:0] rd_byte;

  vsw_mem_if mif ();

  wire [7:0] byte_in   = {shift_reg[6:0], sda_f};
  wire       byte_done = scl_rise && (cnt_reg == 4'h7);
  wire       addr_hit  = (byte_in[7:1] == {DEV_ADDR_HI, addr_sel_s});
  wire       ptr_wr_ok = (ptr_reg <= REG_MISC2) && (ptr_reg != REG_RSVD);
  wire       wr_fire   = (st_reg == ST_WRITE) && byte_done;
  wire [2:0] bit_sel   = 3'(4'h7 - cnt_reg);

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    ack_next   = ack_reg;
    sdoe_next  = sdoe_reg;
    if (start_det) begin
      st_next   = ST_ADDR;
      cnt_next  = 4'h0;
      ack_next  = 1'b0;
      sdoe_next = 1'b0;
    end else if (stop_det) begin
      st_next   = ST_IDLE;
      sdoe_next = 1'b0;
    end else if (st_reg != ST_IDLE) begin
      if (scl_rise) begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg < 4'h8) shift_next = byte_in;
        if (byte_done) begin
          case (st_reg)
            ST_ADDR: begin
              ack_next = addr_hit;
              rw_next  = byte_in[0];
              if (!addr_hit) st_next = ST_IDLE;
            end
            ST_INDEX: begin
              ptr_next = byte_in;
              ack_next = 1'b1;
            end
            ST_WRITE: begin
              ptr_next = ptr_reg + 8'h1;
              ack_next = 1'b1;
            end
            default: ack_next = 1'b0;
          endcase
        end
        if ((st_reg == ST_READ) && (cnt_reg == 4'h8)) begin
          ptr_next = ptr_reg + 8'h1;
          if (sda_f) st_next = ST_IDLE;
        end
      end else if (scl_fall) begin
        if (cnt_reg == 4'h8) begin
          sdoe_next = ack_reg;
        end else if (cnt_reg == 4'h9) begin
          cnt_next  = 4'h0;
          ack_next  = 1'b0;
          sdoe_next = 1'b0;
          case (st_reg)
            ST_ADDR: begin
              st_next   = rw_reg ? ST_READ : ST_INDEX;
              sdoe_next = rw_reg & ~rd_byte[7];
            end
            ST_INDEX: st_next   = ST_WRITE;
            ST_READ:  sdoe_next = ~rd_byte[7];
            default:  st_next   = st_reg;
          endcase
        end else if ((st_reg == ST_READ) && (cnt_reg != 4'h0)) begin
          sdoe_next = ~rd_byte[bit_sel];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      sdoe_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      ack_reg   <= ack_next;
      sdoe_reg  <= sdoe_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_oe_o = sdoe_reg;
  assign sda_o    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and read path
  wire [7:0] wr_data = (ptr_reg == REG_MISC1) ? (byte_in & MISC1_WMASK)
                                               : byte_in;
  assign mif.we    = wr_fire && ptr_wr_ok;
  assign mif.waddr = ptr_reg[MEM_AW-1:0];
  assign mif.wdata = wr_data;
  assign mif.raddr = ptr_reg[MEM_AW-1:0];

  vsw_regmem u_mem (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .bus       (mif.mem)
  );

  assign rd_byte = (ptr_reg == REG_MISC1) ? {cable_s, mif.rdata[3:0]}
                 : ptr_wr_ok               ? mif.rdata
                 :                           8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Control copies and clamp outputs
  logic [7:0] sep_a_reg, sep_b_reg, misc2_reg;
  logic [1:0] misc1_reg;
  logic [1:0] slv_svid_reg, slv_comp_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sep_a_reg    <= REG_RST;
      sep_b_reg    <= REG_RST;
      misc2_reg    <= REG_RST;
      misc1_reg    <= 2'h0;
      slv_svid_reg <= 2'h0;
      slv_comp_reg <= 2'h0;
    end else if (mif.we) begin
      case (ptr_reg)
        REG_SEP_A:  sep_a_reg       <= wr_data;
        REG_SEP_B:  sep_b_reg       <= wr_data;
        REG_SVID_A: slv_svid_reg[1] <= wr_data[SLAVE_BIT];
        REG_SVID_B: slv_svid_reg[0] <= wr_data[SLAVE_BIT];
        REG_COMP_A: slv_comp_reg[1] <= wr_data[SLAVE_BIT];
        REG_COMP_B: slv_comp_reg[0] <= wr_data[SLAVE_BIT];
        REG_MISC1:  misc1_reg       <= wr_data[1:0];
        REG_MISC2:  misc2_reg       <= wr_data;
        default:    misc1_reg       <= misc1_reg;
      endcase
    end
  end

  wire [1:0] m_cvbs = {misc2_reg[M2_CH_A+M2_CVBS], misc2_reg[M2_CVBS]};
  wire [1:0] m_svid = {misc2_reg[M2_CH_A+M2_SVID], misc2_reg[M2_SVID]};
  wire [1:0] m_comp = {misc2_reg[M2_CH_A+M2_COMP], misc2_reg[M2_COMP]};
  wire [1:0] m_lofs = {misc2_reg[M2_CH_A+M2_LOFS], misc2_reg[M2_LOFS]};
  wire [1:0] sep_c  = {sep_a_reg == SEP_CHROMA, sep_b_reg == SEP_CHROMA};
  wire [1:0] sep_p  = {sep_a_reg == SEP_PRPB, sep_b_reg == SEP_PRPB};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_en_o             <= 1'b0;
      field_inv_o             <= 1'b0;
      cvbs_clamp_dis_o        <= 2'h0;
      svid_luma_clamp_dis_o   <= 2'h0;
      svid_chroma_clamp_dis_o <= 2'h0;
      comp_y_clamp_dis_o      <= 2'h0;
      comp_prpb_clamp_dis_o   <= 2'h0;
      comp_low_offset_o       <= 2'h0;
    end else begin
      global_en_o             <= misc1_reg[M1_GLOBAL];
      field_inv_o             <= misc1_reg[M1_FIELDINV];
      cvbs_clamp_dis_o        <= m_cvbs;
      svid_luma_clamp_dis_o   <= m_svid;
      svid_chroma_clamp_dis_o <= m_svid & slv_svid_reg & sep_c;
      comp_y_clamp_dis_o      <= m_comp;
      comp_prpb_clamp_dis_o   <= m_comp & slv_comp_reg & sep_p;
      comp_low_offset_o       <= m_lofs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_IDLE) && !start_det |=> !sda_oe_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("device drives SDA while idle");

  property p_addr_miss;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_ADDR) && byte_done && !addr_hit && !start_det
      && !stop_det |=> (st_reg == ST_IDLE);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address not dropped");

  property p_addr_ack;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_ADDR) && scl_fall && (cnt_reg == 4'h8) && ack_reg
      && !start_det && !stop_det |=> sda_oe_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");

  property p_filter;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(scl_f) |-> $past(sync2_reg[0], 1) && $past(sync2_reg[0], 2)
                     && $past(sync2_reg[0], 3);
  endproperty
  a_filter: assert property (p_filter)
    else $error("SCL accepted before three steady samples");

  property p_read_change;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_READ) && $changed(sda_oe_o)
      |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
  endproperty
  a_read_change: assert property (p_read_change)
    else $error("read data changed away from SCL fall");

  property p_wr_inc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_fire && !start_det && !stop_det |=> ptr_reg == $past(ptr_reg) + 8'h1;
  endproperty
  a_wr_inc: assert property (p_wr_inc)
    else $error("pointer not advanced after write");

  property p_rd_inc;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_READ) && scl_rise && (cnt_reg == 4'h8) && !start_det
      && !stop_det |=> ptr_reg == $past(ptr_reg) + 8'h1;
  endproperty
  a_rd_inc: assert property (p_rd_inc)
    else $error("pointer not advanced after read");

  property p_index;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg == ST_INDEX) && byte_done && !start_det && !stop_det
      |=> ptr_reg == $past(byte_in);
  endproperty
  a_index: assert property (p_index)
    else $error("index byte not loaded into pointer");

  property p_ro_bits;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    mif.we |-> (mif.waddr != REG_RSVD[MEM_AW-1:0])
      && ((ptr_reg != REG_MISC1) || (mif.wdata[7:4] == 4'h0));
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("write reached read-only bits");

  property p_chroma;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 svid_chroma_clamp_dis_o[1] == ($past(misc2_reg[M2_CH_A+M2_SVID])
      && $past(slv_svid_reg[1]) && ($past(sep_a_reg) == SEP_CHROMA));
  endproperty
  a_chroma: assert property (p_chroma)
    else $error("chroma clamp disable mismatch");

endmodule : vsw_i2c_cfg

//--- vsw_mem_if.sv
`timescale 1ns/1ps
interface vsw_mem_if;
  import vsw_pkg::*;
  logic              we;
  logic [MEM_AW-1:0] waddr;
  logic [7:0]        wdata;
  logic [MEM_AW-1:0] raddr;
  logic [7:0]        rdata;
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface : vsw_mem_if

//--- vsw_pkg.sv
package vsw_pkg;

  // Bus address and register map
  localparam logic [5:0] DEV_ADDR_HI = 6'h22;
  localparam logic [7:0] REG_SEP_A   = 8'h00;
  localparam logic [7:0] REG_SEP_B   = 8'h01;
  localparam logic [7:0] REG_SVID_A  = 8'h04;
  localparam logic [7:0] REG_SVID_B  = 8'h05;
  localparam logic [7:0] REG_COMP_A  = 8'h06;
  localparam logic [7:0] REG_COMP_B  = 8'h07;
  localparam logic [7:0] REG_MISC1   = 8'h14;
  localparam logic [7:0] REG_RSVD    = 8'h15;
  localparam logic [7:0] REG_MISC2   = 8'h16;
  localparam int         NUM_REGS    = 23;
  localparam int         MEM_AW      = 5;
  localparam logic [7:0] REG_RST     = 8'h00;

  // Field layout
  localparam int         CABLE_W     = 4;
  localparam int         CABLE_LSB   = 4;
  localparam logic [7:0] MISC1_WMASK = 8'h0f;
  localparam int         M1_GLOBAL   = 0;
  localparam int         M1_FIELDINV = 1;
  localparam int         SLAVE_BIT   = 7;
  localparam int         M2_CVBS     = 0;
  localparam int         M2_SVID     = 1;
  localparam int         M2_COMP     = 2;
  localparam int         M2_LOFS     = 3;
  localparam int         M2_CH_A     = 4;
  localparam logic [7:0] SEP_CHROMA  = 8'h25;
  localparam logic [7:0] SEP_PRPB    = 8'h24;

  // Serial clock filter: count of crystal periods
  localparam int         GLITCH_CLKS = 3;
  localparam logic [1:0] GLITCH_MAX  = 2'(GLITCH_CLKS - 1);
  localparam logic [6:0] SYNC_RST    = 7'h03;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_INDEX = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_READ  = 5'b10000
  } vsw_state_t;

endpackage : vsw_pkg

//--- vsw_regmem.sv
`timescale 1ns/1ps
module vsw_regmem (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  vsw_mem_if.mem    bus
);
  import vsw_pkg::*;

  logic [7:0] mem_reg [NUM_REGS];
  logic [7:0] rdata_reg;

  assign bus.rdata = rdata_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= REG_RST;
      end
      rdata_reg <= REG_RST;
    end else begin
      if (bus.we && (int'(bus.waddr) < NUM_REGS)) begin
        mem_reg[bus.waddr] <= bus.wdata;
      end
      rdata_reg <= (int'(bus.raddr) < NUM_REGS) ? mem_reg[bus.raddr]
                                                : REG_RST;
    end
  end

endmodule : vsw_regmem
